// ===== flash_seq_pkg.sv
package flash_seq_pkg;

  // Instruction operand widths
  localparam int PTR_W = 16;
  localparam int DATA_W = 16;

  // Register port
  localparam int REG_ADDR_W = 4;
  localparam int REG_DATA_W = 8;
  localparam logic [REG_ADDR_W-1:0] OFS_CONTROL = 4'h0;
  localparam logic [REG_ADDR_W-1:0] OFS_STATUS = 4'h1;
  localparam logic [REG_DATA_W-1:0] REG_ZERO = 8'h00;

  // Control register fields
  localparam int CTRL_W = 5;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_ERASE_BIT = 1;
  localparam int CTRL_WRITE_BIT = 2;
  localparam int CTRL_FUSE_BIT = 3;
  localparam int CTRL_CLEAR_BIT = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

  // Accepted command codes in the low control bits
  localparam logic [CTRL_W-1:0] CMD_LOAD = 5'h01;
  localparam logic [CTRL_W-1:0] CMD_ERASE = 5'h03;
  localparam logic [CTRL_W-1:0] CMD_WRITE = 5'h05;
  localparam logic [CTRL_W-1:0] CMD_READ_FUSE = 5'h09;
  localparam logic [CTRL_W-1:0] CMD_CLEAR = 5'h11;

  // Status register fields
  localparam int STAT_LOADED_BIT = 0;
  localparam int STAT_FUSE_BIT = 1;
  localparam int STAT_EEPROM_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;

  // Store instruction window after a control write
  localparam int WINDOW_W = 3;
  localparam logic [WINDOW_W-1:0] STORE_WINDOW = 3'h4;
  localparam logic [WINDOW_W-1:0] WINDOW_LAST = 3'h1;
  localparam logic [WINDOW_W-1:0] WINDOW_NONE = 3'h0;

  // Page layout defaults
  localparam int WORD_IDX_W_DEF = 5;
  localparam int PAGE_W_DEF = PTR_W - 1 - WORD_IDX_W_DEF;
  localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;

  // Programming time
  localparam int CLOCK_PERIOD_NS = 8;
  localparam int PROG_TIME_MIN_NS = 3700000;
  localparam int PROG_TIME_MAX_NS = 4500000;
  localparam int PROG_CYCLES_MIN = (PROG_TIME_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int PROG_CYCLES_MAX = PROG_TIME_MAX_NS / CLOCK_PERIOD_NS;
  localparam int TIMER_W = 20;

  typedef struct packed {
    logic [PTR_W-1:0] ptr;
    logic [DATA_W-1:0] data;
  } store_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ERASE = 2'b01,
    ST_WRITE = 2'b10
  } seq_state_t;

endpackage

// ===== page_buffer.sv
module page_buffer
  import flash_seq_pkg::*;
#(
  parameter int WORD_IDX_W = WORD_IDX_W_DEF
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // Write side
  input wire logic i_clear,
  input wire logic i_we,
  input wire logic [WORD_IDX_W-1:0] i_widx,
  input wire logic [DATA_W-1:0] i_wdata,
  // Read side
  input wire logic [WORD_IDX_W-1:0] i_ridx,
  output logic [DATA_W-1:0] o_rdata,
  output logic [(1<<WORD_IDX_W)-1:0] o_loaded
);

  localparam int WORDS = 1 << WORD_IDX_W;

  logic [DATA_W-1:0] mem_r [WORDS];

  // Any entry may be loaded in any order
  for (genvar g = 0; g < WORDS; g++) begin : g_entry
    always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
        mem_r[g] <= ERASED_WORD;
        o_loaded[g] <= 1'b0;
      end else if (i_clk_en) begin
        if (i_clear) begin
          mem_r[g] <= ERASED_WORD;
          o_loaded[g] <= 1'b0;
        end else if (i_we && i_widx == WORD_IDX_W'(g)) begin
          mem_r[g] <= i_wdata;
          o_loaded[g] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_rdata <= ERASED_WORD;
    end else if (i_clk_en) begin
      o_rdata <= mem_r[i_ridx];
    end
  end

endmodule // page_buffer

// ===== flash_self_program_sequencer.sv
// The implementer's own choices: the strobed register port and the register offsets.
module flash_self_program_sequencer
  import flash_seq_pkg::*;
#(
  parameter int WORD_IDX_W = WORD_IDX_W_DEF,
  parameter int PAGE_W = PTR_W - 1 - WORD_IDX_W,
  parameter int PROG_CYCLES = PROG_CYCLES_MIN
) (
  // Clock, reset, enable
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // Register port
  input wire logic [REG_ADDR_W-1:0] i_addr,
  input wire logic [REG_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [REG_DATA_W-1:0] o_rdata,
  // CPU side
  input wire logic i_store_program_instruction,
  input wire store_req_t i_store_req,
  input wire logic i_load_program_instruction,
  input wire logic [PTR_W-1:0] i_load_ptr,
  output logic o_cpu_halt,
  output logic [PTR_W-2:0] o_read_word_addr,
  output logic o_read_byte_hi,
  // Fuse and EEPROM status
  input wire logic i_self_program_fuse,
  input wire logic i_eeprom_busy,
  input wire logic i_eeprom_write_start,
  // Flash array
  output logic o_flash_erase,
  output logic o_flash_write,
  output logic [PAGE_W-1:0] o_flash_page,
  output logic o_flash_word_valid,
  output logic [WORD_IDX_W-1:0] o_flash_word,
  output logic [DATA_W-1:0] o_flash_wdata
);

  localparam int WORDS = 1 << WORD_IDX_W;
  localparam logic [TIMER_W-1:0] TIMER_END = TIMER_W'(PROG_CYCLES - 1);
  localparam logic [WORD_IDX_W-1:0] LAST_WORD = WORD_IDX_W'(WORDS - 1);

  seq_state_t state_r;
  logic [CTRL_W-1:0] program_store_control_r;
  logic [WINDOW_W-1:0] window_r;
  logic [TIMER_W-1:0] timer_r;
  logic fuse_en_r;
  logic stream_r;
  logic [WORD_IDX_W-1:0] stream_idx_r;
  logic [WORDS-1:0] loaded;
  logic any_loaded;
  logic ctrl_legal;
  logic ctrl_wr_ok;
  logic store_go;
  logic done;
  logic buf_clear;
  logic buf_we;
  logic [WORD_IDX_W-1:0] word_in_page_field;
  logic [PAGE_W-1:0] page_select_field;

  // Pointer split: bit 0 byte, then word, then page
  assign word_in_page_field = i_store_req.ptr[WORD_IDX_W:1];
  assign page_select_field = i_store_req.ptr[PTR_W-1:WORD_IDX_W+1];
  assign any_loaded = |loaded;

  assign ctrl_legal = i_wdata[CTRL_W-1:0] inside {CMD_LOAD, CMD_ERASE, CMD_WRITE, CMD_READ_FUSE, CMD_CLEAR};
  assign ctrl_wr_ok = i_wr && i_addr == OFS_CONTROL && ctrl_legal && !i_eeprom_busy
                      && state_r == ST_IDLE;
  assign store_go = i_store_program_instruction && fuse_en_r && window_r != WINDOW_NONE
                    && !i_eeprom_busy && state_r == ST_IDLE;
  assign done = state_r != ST_IDLE && timer_r == TIMER_END;
  assign buf_we = store_go && program_store_control_r == CMD_LOAD;
  // An EEPROM start also beats a load in the same cycle
  assign buf_clear = (ctrl_wr_ok && i_wdata[CTRL_W-1:0] == CMD_CLEAR)
                     || (state_r == ST_WRITE && done)
                     || i_eeprom_write_start;

  page_buffer #(
    .WORD_IDX_W(WORD_IDX_W)
  ) u_buffer (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .i_clear(buf_clear),
    .i_we(buf_we),
    .i_widx(word_in_page_field),
    .i_wdata(i_store_req.data),
    .i_ridx(stream_idx_r),
    .o_rdata(o_flash_wdata),
    .o_loaded(loaded)
  );

  // Fuse level taken while reset is held
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      fuse_en_r <= ~i_self_program_fuse;
    end
  end

  // Control register and store window
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      program_store_control_r <= CTRL_RESET;
      window_r <= WINDOW_NONE;
    end else if (i_clk_en) begin
      if (ctrl_wr_ok) begin
        program_store_control_r <= i_wdata[CTRL_W-1:0];
        window_r <= STORE_WINDOW;
      end else if (store_go) begin
        window_r <= WINDOW_NONE;
        if (!(program_store_control_r inside {CMD_ERASE, CMD_WRITE})) begin
          program_store_control_r <= CTRL_RESET;
        end
      end else if (done) begin
        program_store_control_r <= CTRL_RESET;
      end else if (window_r != WINDOW_NONE) begin
        window_r <= window_r - WINDOW_LAST;
        if (window_r == WINDOW_LAST) begin
          program_store_control_r <= CTRL_RESET;
        end
      end
    end
  end

  // Sequencer, halt and programming timer
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
      timer_r <= '0;
      o_cpu_halt <= 1'b0;
      o_flash_erase <= 1'b0;
      o_flash_write <= 1'b0;
      o_flash_page <= '0;
    end else if (i_clk_en) begin
      unique case (state_r)
        ST_IDLE: begin
          timer_r <= '0;
          if (store_go && program_store_control_r == CMD_ERASE) begin
            state_r <= ST_ERASE;
            o_flash_page <= page_select_field;
            o_flash_erase <= 1'b1;
            o_cpu_halt <= 1'b1;
          end else if (store_go && program_store_control_r == CMD_WRITE) begin
            state_r <= ST_WRITE;
            o_flash_page <= page_select_field;
            o_flash_write <= 1'b1;
            o_cpu_halt <= 1'b1;
          end
        end
        ST_ERASE, ST_WRITE: begin
          timer_r <= timer_r + TIMER_W'(1);
          if (done) begin
            state_r <= ST_IDLE;
            o_flash_erase <= 1'b0;
            o_flash_write <= 1'b0;
            o_cpu_halt <= 1'b0;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          o_cpu_halt <= 1'b0;
        end
      endcase
    end
  end

  // Buffer words handed to the array during a page write
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      stream_r <= 1'b0;
      stream_idx_r <= '0;
      o_flash_word_valid <= 1'b0;
      o_flash_word <= '0;
    end else if (i_clk_en) begin
      o_flash_word_valid <= stream_r;
      o_flash_word <= stream_idx_r;
      if (store_go && program_store_control_r == CMD_WRITE) begin
        stream_r <= 1'b1;
        stream_idx_r <= '0;
      end else if (stream_r) begin
        stream_idx_r <= stream_idx_r + WORD_IDX_W'(1);
        if (stream_idx_r == LAST_WORD) begin
          stream_r <= 1'b0;
        end
      end
    end
  end

  // Byte-wise program read address
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_read_word_addr <= '0;
      o_read_byte_hi <= 1'b0;
    end else if (i_clk_en && i_load_program_instruction) begin
      o_read_word_addr <= i_load_ptr[PTR_W-1:1];
      o_read_byte_hi <= i_load_ptr[0];
    end
  end

  // Register read, data one cycle after the strobe
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_rdata <= REG_ZERO;
    end else if (i_clk_en) begin
      o_rdata <= REG_ZERO;
      if (i_rd && i_addr == OFS_CONTROL) begin
        o_rdata <= REG_DATA_W'(program_store_control_r);
      end else if (i_rd && i_addr == OFS_STATUS) begin
        o_rdata[STAT_LOADED_BIT] <= any_loaded;
        o_rdata[STAT_FUSE_BIT] <= fuse_en_r;
        o_rdata[STAT_EEPROM_BIT] <= i_eeprom_busy;
        o_rdata[STAT_BUSY_BIT] <= state_r != ST_IDLE;
      end
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  property p_fuse_gate;
    !fuse_en_r |-> state_r == ST_IDLE && !buf_we;
  endproperty
  a_fuse_gate: assert property (p_fuse_gate) else $error("store acted with fuse off");

  property p_load_word;
    i_clk_en && buf_we && !buf_clear |=> loaded[$past(word_in_page_field)];
  endproperty
  a_load_word: assert property (p_load_word) else $error("word load not stored");

  property p_erase_start;
    i_clk_en && store_go && program_store_control_r == CMD_ERASE
      |=> state_r == ST_ERASE && o_flash_erase && o_flash_page == $past(page_select_field);
  endproperty
  a_erase_start: assert property (p_erase_start) else $error("erase not started on page");

  property p_halt_erase;
    state_r == ST_ERASE |-> o_cpu_halt && o_flash_erase;
  endproperty
  a_halt_erase: assert property (p_halt_erase) else $error("cpu not halted in erase");

  property p_write_start;
    i_clk_en && store_go && program_store_control_r == CMD_WRITE
      |=> state_r == ST_WRITE && o_flash_write && o_flash_page == $past(page_select_field);
  endproperty
  a_write_start: assert property (p_write_start) else $error("write not started on page");

  property p_halt_write;
    state_r == ST_WRITE |-> o_cpu_halt && o_flash_write;
  endproperty
  a_halt_write: assert property (p_halt_write) else $error("cpu not halted in write");

  property p_clear_after_write;
    i_clk_en && state_r == ST_WRITE && done |=> !any_loaded && state_r == ST_IDLE;
  endproperty
  a_clear_after_write: assert property (p_clear_after_write) else $error("buffer kept after write");

  property p_eeprom_discard;
    i_clk_en && i_eeprom_write_start |=> !any_loaded;
  endproperty
  a_eeprom_discard: assert property (p_eeprom_discard) else $error("buffer kept on eeprom write");

  property p_window_timeout;
    i_clk_en && window_r == WINDOW_LAST && !i_store_program_instruction && !ctrl_wr_ok && state_r == ST_IDLE
      |=> program_store_control_r == CTRL_RESET;
  endproperty
  a_window_timeout: assert property (p_window_timeout) else $error("command bits not cleared");

  property p_illegal_ignored;
    i_clk_en && i_wr && i_addr == OFS_CONTROL && (!ctrl_legal || i_eeprom_busy) && !store_go && !done
      && window_r == WINDOW_NONE |=> $stable(program_store_control_r);
  endproperty
  a_illegal_ignored: assert property (p_illegal_ignored) else $error("bad control write took effect");

  property p_op_length;
    $past(i_clk_en) && $past(state_r) != ST_IDLE && state_r == ST_IDLE |-> $past(timer_r) == TIMER_END;
  endproperty
  a_op_length: assert property (p_op_length) else $error("operation length wrong");

  property p_byte_select;
    i_clk_en && i_load_program_instruction |=> o_read_byte_hi == $past(i_load_ptr[0]);
  endproperty
  a_byte_select: assert property (p_byte_select) else $error("byte select wrong");

  c_erase: cover property (i_clk_en && store_go && program_store_control_r == CMD_ERASE);
  c_write: cover property (i_clk_en && store_go && program_store_control_r == CMD_WRITE);
  c_load: cover property (buf_we ##1 any_loaded);
  c_timeout: cover property (window_r == WINDOW_LAST ##1 program_store_control_r == CTRL_RESET);

endmodule // flash_self_program_sequencer

// ===== cpu_model.sv
module cpu_model
  import flash_seq_pkg::*;
(
  // Clock and halt
  input wire logic i_clock,
  input wire logic i_halt,
  // Register port
  output logic [REG_ADDR_W-1:0] o_addr,
  output logic [REG_DATA_W-1:0] o_wdata,
  output logic o_wr,
  output logic o_rd,
  // Instructions
  output logic o_store_program_instruction,
  output store_req_t o_store_req,
  output logic o_load_program_instruction,
  output logic [PTR_W-1:0] o_load_ptr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_addr = '0;
    o_wdata = '0;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_store_program_instruction = 1'b0;
    o_store_req = '0;
    o_load_program_instruction = 1'b0;
    o_load_ptr = '0;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clock);
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge i_clock);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clock);
    o_rd <= 1'b0;
  endtask

  // Command write, store, then stay idle while halted
  task automatic store(input logic [7:0] c, input logic [15:0] p, input logic [15:0] d, output int n);
    int i;
    wr(OFS_CONTROL, c);
    @(posedge i_clock);
    o_store_program_instruction <= 1'b1;
    o_store_req <= '{ptr: p, data: d};
    @(posedge i_clock);
    o_store_program_instruction <= 1'b0;
    o_store_req <= ~o_store_req;
    n = 0;
    i = 0;
    do begin
      @(negedge i_clock);
      if (i_halt === 1'b1) n++;
      i++;
    end while ((i < 3 || i_halt === 1'b1) && i < 200);
  endtask

  task automatic read_byte(input logic [15:0] p);
    @(posedge i_clock);
    o_load_program_instruction <= 1'b1;
    o_load_ptr <= p;
    @(posedge i_clock);
    o_load_program_instruction <= 1'b0;
    o_load_ptr <= ~p;
  endtask
endmodule // cpu_model

// ===== tb.sv
module tb
  import flash_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PROG = 40;
  logic i_clock, i_rst_n, clk_en, fuse, ee_busy, ee_start, wr, rd, store_i, load_i, halt, rbh, fer, fwr, fwv, rd_d;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  store_req_t req;
  logic [15:0] load_ptr, fdata;
  logic [14:0] rwa;
  logic [9:0] fpage, pg;
  logic [4:0] fword;
  logic [31:0] lfsr_s, r;
  logic [15:0] buf_m [32];
  logic [7:0] codes [8];
  logic [7:0] rd_q [$];
  logic [31:0] wd_q [$];
  int err_total, compares, cyc, n;

  flash_self_program_sequencer #(.PROG_CYCLES(PROG)) dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_clk_en(clk_en), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_store_program_instruction(store_i), .i_store_req(req), .i_load_program_instruction(load_i),
    .i_load_ptr(load_ptr), .o_cpu_halt(halt),
    .o_read_word_addr(rwa), .o_read_byte_hi(rbh), .i_self_program_fuse(fuse), .i_eeprom_busy(ee_busy),
    .i_eeprom_write_start(ee_start), .o_flash_erase(fer), .o_flash_write(fwr), .o_flash_page(fpage),
    .o_flash_word_valid(fwv), .o_flash_word(fword), .o_flash_wdata(fdata));

  cpu_model cpu (.i_clock(i_clock), .i_halt(halt), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd),
    .o_store_program_instruction(store_i), .o_store_req(req), .o_load_program_instruction(load_i),
    .o_load_ptr(load_ptr));

  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  function automatic logic [31:0] rnd();
    lfsr_s = {lfsr_s[30:0], lfsr_s[31] ^ lfsr_s[21] ^ lfsr_s[1] ^ lfsr_s[0]};
    return lfsr_s;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic rdx(input logic [3:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    cpu.rd(a);
  endtask

  task automatic load(input logic [4:0] w);
    r = rnd();
    buf_m[w] = r[31:16];
    cpu.store({3'h0, CMD_LOAD}, {pg, w, r[0]}, r[31:16], n);
  endtask

  task automatic do_reset();
    i_rst_n <= 1'b0;
    repeat (16) @(posedge i_clock);
    i_rst_n <= 1'b1;
  endtask

  // Results are matched against the oldest note once settled
  always @(posedge i_clock) rd_d <= rd;
  always @(negedge i_clock) begin
    if (rd_d === 1'b1) chk("rdata", rd_q.size() > 0 ? {24'h0, rd_q.pop_front()} : 32'hXXXXXXXX, {24'h0, rdata});
    if (fwv === 1'b1) chk("flash word", wd_q.size() > 0 ? wd_q.pop_front() : 32'hXXXXXXXX, {fwr, fpage, fword, fdata});
    if (fer === 1'b1) chk("erase page", {1'b1, pg}, {fer & ~fwr & halt, fpage});
  end

  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  initial begin
    {i_rst_n, fuse, ee_busy, ee_start, err_total, compares, cyc} = '0;
    clk_en = 1'b1;
    lfsr_s = 32'hb9ef;
    codes = '{8'h01, 8'h03, 8'h05, 8'h09, 8'h07, 8'h1F, 8'h02, 8'h0D};
    do_reset();
    rdx(OFS_STATUS, 8'h02);
    foreach (codes[k]) begin
      cpu.wr(OFS_CONTROL, codes[k]);
      rdx(OFS_CONTROL, k < 4 ? codes[k] : 8'h00);
      repeat (6) @(posedge i_clock);
    end
    rdx(4'hA, 8'h00);
    cpu.wr(OFS_CONTROL, 8'h01);
    repeat (6) @(posedge i_clock);
    rdx(OFS_CONTROL, 8'h00);
    // Enable low freezes the store window
    cpu.wr(OFS_CONTROL, 8'h01);
    clk_en <= 1'b0;
    repeat (6) @(posedge i_clock);
    clk_en <= 1'b1;
    rdx(OFS_CONTROL, 8'h01);
    ee_busy <= 1'b1;
    cpu.wr(OFS_CONTROL, 8'h01);
    rdx(OFS_CONTROL, 8'h00);
    rdx(OFS_STATUS, 8'h06);
    ee_busy <= 1'b0;
    repeat (6) @(posedge i_clock);
    r = rnd();
    pg = r[9:0];
    load(5'h03);
    rdx(OFS_STATUS, 8'h03);
    ee_start <= 1'b1;
    @(posedge i_clock);
    ee_start <= 1'b0;
    rdx(OFS_STATUS, 8'h02);
    load(5'h1F);
    cpu.wr(OFS_CONTROL, {3'h0, CMD_CLEAR});
    rdx(OFS_STATUS, 8'h02);
    repeat (6) @(posedge i_clock);
    // A quarter of the page before erase, a quarter after, scattered order
    foreach (buf_m[w]) buf_m[w] = ERASED_WORD;
    for (int k = 0; k < 8; k++) load(5'(k * 7 + 3));
    r = rnd();
    cpu.store({3'h0, CMD_ERASE}, {pg, 6'h2B}, r[15:0], n);
    chk("erase halt", PROG, n);
    for (int k = 8; k < 16; k++) load(5'(k * 7 + 3));
    foreach (buf_m[w]) wd_q.push_back({1'b1, pg, 5'(w), buf_m[w]});
    cpu.store({3'h0, CMD_WRITE}, {pg, 6'h00}, r[31:16], n);
    chk("write halt", PROG, n);
    chk("words left", 0, wd_q.size());
    rdx(OFS_STATUS, 8'h02);
    rdx(OFS_CONTROL, 8'h00);
    for (int b = 0; b < 2; b++) begin
      r = rnd();
      cpu.read_byte({r[15:1], b[0]});
      @(negedge i_clock);
      chk("byte load", {r[15:1], b[0]}, {rwa, rbh});
    end
    fuse <= 1'b1;
    do_reset();
    rdx(OFS_STATUS, 8'h00);
    load(5'h00);
    rdx(OFS_STATUS, 8'h00);
    repeat (4) @(posedge i_clock);
    print_verdict();
  end
endmodule // tb
